// ### rtl/srl_latch_unit.sv
// set-reset latch unit with selectable sources and an axi4-lite slave
//
// Summary of operation
// - level set/reset core, active-high inputs
// - four selectable set and reset sources
// - reset wins when both inputs high
// - firmware pulse bits clear themselves
// - comparators usable, optionally synced to timer
// - external pin can set or reset
// - periodic pulse period from 3-bit field
// - separate enables route periodic pulse
// - true and inverted outputs enabled separately
// - pin driven only when direction is output
// - reset leaves latch state undefined
// - pulse every 4 to 512 cycles
// - master enable off disables both pin drivers
// - enabled outputs show state and its inverse
// - firmware pulse lasts one cycle, reads zero
`timescale 1ns/10ps
module srl_latch_unit (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [srl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [srl_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [srl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [srl_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // latch sources
  input wire logic cmp_a_out,
  input wire logic cmp_b_out,
  input wire logic timer_clk_tick,
  input wire logic latch_ext_input_pin,
  // pin drivers
  output logic true_out_pin_o,
  output logic true_out_pin_oe,
  output logic inverted_out_pin_o,
  output logic inverted_out_pin_oe
);

  // software-visible registers
  logic latch_master_en_q;  // pin drivers on/off
  logic [srl_pkg::CF_DIV_W-1:0] periodic_pulse_divider_sel_q;  // period
  logic true_out_en_q;  // true output enable
  logic inverted_out_en_q;  // inverted output enable
  logic fw_set_pulse_q;  // one-cycle firmware set
  logic fw_reset_pulse_q;  // one-cycle firmware reset
  logic [7:0] latch_source_enables_q;  // per-source routing
  logic [7:0] pin_cfg_q;  // directions and sync options

  // source path signals
  logic cmp_a_synced_out_q;  // comparator a held at timer tick
  logic cmp_b_synced_out_q;  // comparator b held at timer tick
  logic cmp_a_src;  // comparator a as seen by latch
  logic cmp_b_src;  // comparator b as seen by latch
  logic periodic_pulse;  // divider output
  logic set_in;  // combined set
  logic rst_in;  // combined reset
  logic latch_state_q;  // stored latch bit, never reset

  // write channel holding
  logic aw_held_q;  // address taken, waiting for data
  logic w_held_q;  // data taken, waiting for address
  logic [srl_pkg::ADDR_W-1:0] awaddr_q;  // held write address
  logic [7:0] wdata_q;  // held low data byte
  logic wstrb0_q;  // held low byte strobe
  logic aw_take;  // address handshake this cycle
  logic w_take;  // data handshake this cycle
  logic wr_go;  // both halves present, perform write
  logic [srl_pkg::ADDR_W-1:0] wr_addr;  // address used for write
  logic [7:0] wr_byte;  // data byte used for write
  logic wr_lane0;  // byte lane 0 enabled
  logic wr_ctrl;  // write hits latch_ctrl_first
  logic wr_src;  // write hits latch_source_enables
  logic wr_pin;  // write hits pin configuration
  logic wr_map;  // write hits any register

  // read decode
  logic ar_take;  // read address handshake this cycle
  logic [7:0] rd_byte;  // read mux output
  logic rd_map;  // read hits a register

  // ---------------- write path ----------------

  // handshake terms; each channel is held until the response is taken
  always_comb begin
    aw_take = s_axi_awvalid && s_axi_awready;
    w_take = s_axi_wvalid && s_axi_wready;
  end

  // address and data may arrive in either order
  always_comb begin
    wr_go = (aw_held_q || aw_take) && (w_held_q || w_take) && !s_axi_bvalid;
    wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wr_byte = w_held_q ? wdata_q : s_axi_wdata[7:0];
    wr_lane0 = w_held_q ? wstrb0_q : s_axi_wstrb[0];
  end

  // address decode for writes; the status word is read only
  always_comb begin
    wr_ctrl = wr_addr == srl_pkg::OFS_LATCH_CTRL_FIRST;
    wr_src = wr_addr == srl_pkg::OFS_LATCH_SOURCE_EN;
    wr_pin = wr_addr == srl_pkg::OFS_PIN_CFG;
    wr_map = wr_ctrl || wr_src || wr_pin;
  end

  // ready is offered while the channel is empty and no response waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !wr_go && !(aw_held_q || aw_take) && !s_axi_bvalid;
      s_axi_wready <= !wr_go && !(w_held_q || w_take) && !s_axi_bvalid;
    end
  end

  // hold whichever half arrived first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_held_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_q <= 1'b1;
          wdata_q <= s_axi_wdata[7:0];
          wstrb0_q <= s_axi_wstrb[0];
        end
      end
    end
  end

  // write response, slverr for an unmapped or read-only address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= srl_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_map ? srl_pkg::RESP_OKAY : srl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- registers ----------------

  // control word: enables and divider selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_master_en_q <= srl_pkg::RST_CTRL_FIRST[srl_pkg::CF_MASTER_EN];
      periodic_pulse_divider_sel_q <= srl_pkg::RST_CTRL_FIRST[
        srl_pkg::CF_DIV_LSB +: srl_pkg::CF_DIV_W];
      true_out_en_q <= srl_pkg::RST_CTRL_FIRST[srl_pkg::CF_TRUE_EN];
      inverted_out_en_q <= srl_pkg::RST_CTRL_FIRST[srl_pkg::CF_INV_EN];
    end else if (wr_go && wr_ctrl && wr_lane0) begin
      latch_master_en_q <= wr_byte[srl_pkg::CF_MASTER_EN];
      periodic_pulse_divider_sel_q <=
        wr_byte[srl_pkg::CF_DIV_LSB +: srl_pkg::CF_DIV_W];
      true_out_en_q <= wr_byte[srl_pkg::CF_TRUE_EN];
      inverted_out_en_q <= wr_byte[srl_pkg::CF_INV_EN];
    end
  end

  // firmware pulses: high for the one cycle after the write, then clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fw_set_pulse_q <= srl_pkg::RST_CTRL_FIRST[srl_pkg::CF_FW_SET];
      fw_reset_pulse_q <= srl_pkg::RST_CTRL_FIRST[srl_pkg::CF_FW_RESET];
    end else begin
      fw_set_pulse_q <= wr_go && wr_ctrl && wr_lane0 &&
        wr_byte[srl_pkg::CF_FW_SET];
      fw_reset_pulse_q <= wr_go && wr_ctrl && wr_lane0 &&
        wr_byte[srl_pkg::CF_FW_RESET];
    end
  end

  // source enable word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_source_enables_q <= srl_pkg::RST_SOURCE_EN;
    end else if (wr_go && wr_src && wr_lane0) begin
      latch_source_enables_q <= wr_byte;
    end
  end

  // pin direction and comparator sync word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_cfg_q <= srl_pkg::RST_PIN_CFG;
    end else if (wr_go && wr_pin && wr_lane0) begin
      pin_cfg_q <= wr_byte;
    end
  end

  // ---------------- read path ----------------

  always_comb begin
    ar_take = s_axi_arvalid && s_axi_arready;
  end

  // read mux; pulse bits always read zero
  always_comb begin
    rd_byte = 8'h00;
    rd_map = 1'b1;
    unique case (s_axi_araddr)
      srl_pkg::OFS_LATCH_CTRL_FIRST: begin
        rd_byte[srl_pkg::CF_MASTER_EN] = latch_master_en_q;
        rd_byte[srl_pkg::CF_DIV_LSB +: srl_pkg::CF_DIV_W] =
          periodic_pulse_divider_sel_q;
        rd_byte[srl_pkg::CF_TRUE_EN] = true_out_en_q;
        rd_byte[srl_pkg::CF_INV_EN] = inverted_out_en_q;
      end
      srl_pkg::OFS_LATCH_SOURCE_EN: begin
        rd_byte = latch_source_enables_q;
      end
      srl_pkg::OFS_PIN_CFG: begin
        rd_byte = pin_cfg_q;
      end
      srl_pkg::OFS_STATUS: begin
        // state masked until it has been defined by firmware or a source
        rd_byte[srl_pkg::ST_STATE] = latch_state_q === 1'b1;
        rd_byte[srl_pkg::ST_SET_IN] = set_in;
        rd_byte[srl_pkg::ST_RST_IN] = rst_in;
      end
      default: begin
        rd_map = 1'b0;  // unmapped
      end
    endcase
  end

  // one read at a time; address taken only while no data is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
    end
  end

  // read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= srl_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_map ? srl_pkg::RESP_OKAY : srl_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- latch sources ----------------

  // comparator values captured on each timer tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_a_synced_out_q <= 1'b0;
      cmp_b_synced_out_q <= 1'b0;
    end else if (timer_clk_tick) begin
      cmp_a_synced_out_q <= cmp_a_out;
      cmp_b_synced_out_q <= cmp_b_out;
    end
  end

  // pick raw or timer-synced comparator per option bit
  always_comb begin
    cmp_a_src = pin_cfg_q[srl_pkg::PC_CMPA_SYNC] ?
      cmp_a_synced_out_q : cmp_a_out;
    cmp_b_src = pin_cfg_q[srl_pkg::PC_CMPB_SYNC] ?
      cmp_b_synced_out_q : cmp_b_out;
  end

  // periodic pulse from the divider
  srl_pulse_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .div_sel(periodic_pulse_divider_sel_q),
    .pulse_q(periodic_pulse)
  );

  // combine enabled sources; firmware pulses always take part
  always_comb begin
    set_in = fw_set_pulse_q
      | (latch_source_enables_q[srl_pkg::SE_SET_CMPA] & cmp_a_src)
      | (latch_source_enables_q[srl_pkg::SE_SET_CMPB] & cmp_b_src)
      | (latch_source_enables_q[srl_pkg::SE_SET_PIN] &
         latch_ext_input_pin)
      | (latch_source_enables_q[srl_pkg::SE_SET_PER] &
         periodic_pulse);
    rst_in = fw_reset_pulse_q
      | (latch_source_enables_q[srl_pkg::SE_RST_CMPA] & cmp_a_src)
      | (latch_source_enables_q[srl_pkg::SE_RST_CMPB] & cmp_b_src)
      | (latch_source_enables_q[srl_pkg::SE_RST_PIN] &
         latch_ext_input_pin)
      | (latch_source_enables_q[srl_pkg::SE_RST_PER] &
         periodic_pulse);
  end

  // ---------------- latch core ----------------

  // storage bit; no reset term, so its value after reset is unknown.
  // follows set and reset levels each cycle, reset dominant.
  always_ff @(posedge aclk) begin
    if (rst_in) begin
      latch_state_q <= 1'b0;
    end else if (set_in) begin
      latch_state_q <= 1'b1;
    end
  end

  // ---------------- pin drivers ----------------

  // enable needs master, own enable and output direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      true_out_pin_oe <= 1'b0;
      inverted_out_pin_oe <= 1'b0;
    end else begin
      true_out_pin_oe <= latch_master_en_q && true_out_en_q &&
        !pin_cfg_q[srl_pkg::PC_TRUE_DIR];
      inverted_out_pin_oe <= latch_master_en_q && inverted_out_en_q &&
        !pin_cfg_q[srl_pkg::PC_INV_DIR];
    end
  end

  // data gated so an undefined state never leaves an idle pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      true_out_pin_o <= 1'b0;
      inverted_out_pin_o <= 1'b0;
    end else begin
      true_out_pin_o <= latch_master_en_q && true_out_en_q &&
        !pin_cfg_q[srl_pkg::PC_TRUE_DIR] && latch_state_q;
      inverted_out_pin_o <= latch_master_en_q && inverted_out_en_q &&
        !pin_cfg_q[srl_pkg::PC_INV_DIR] && !latch_state_q;
    end
  end

  // protection bits are accepted and ignored
  logic unused_prot;
  always_comb begin
    unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8],
      s_axi_wstrb[3:1]};
  end

endmodule : srl_latch_unit

// ### rtl/srl_pkg.sv
// constants shared by the set-reset latch unit
package srl_pkg;

  // bus geometry
  localparam int ADDR_W = 12;  // axi byte address width
  localparam int DATA_W = 32;  // axi data width

  // register byte offsets
  localparam logic [11:0] OFS_LATCH_CTRL_FIRST = 12'h000;  // control
  localparam logic [11:0] OFS_LATCH_SOURCE_EN = 12'h004;  // source enables
  localparam logic [11:0] OFS_PIN_CFG = 12'h008;  // directions and sync
  localparam logic [11:0] OFS_STATUS = 12'h00c;  // live state, read only

  // latch_ctrl_first fields
  localparam int CF_MASTER_EN = 7;  // latch_master_en
  localparam int CF_DIV_LSB = 4;  // periodic_pulse_divider_sel lsb
  localparam int CF_DIV_W = 3;  // periodic_pulse_divider_sel width
  localparam int CF_TRUE_EN = 3;  // true_out_en
  localparam int CF_INV_EN = 2;  // inverted_out_en
  localparam int CF_FW_SET = 1;  // fw_set_pulse, reads zero
  localparam int CF_FW_RESET = 0;  // fw_reset_pulse, reads zero

  // latch_source_enables fields
  localparam int SE_SET_PIN = 7;  // pin onto set
  localparam int SE_SET_PER = 6;  // periodic_to_set_en
  localparam int SE_SET_CMPB = 5;  // comparator b onto set
  localparam int SE_SET_CMPA = 4;  // comparator a onto set
  localparam int SE_RST_PIN = 3;  // pin onto reset
  localparam int SE_RST_PER = 2;  // periodic_to_reset_en
  localparam int SE_RST_CMPB = 1;  // comparator b onto reset
  localparam int SE_RST_CMPA = 0;  // comparator a onto reset

  // pin configuration fields
  localparam int PC_TRUE_DIR = 0;  // port_direction_bit of true pin
  localparam int PC_INV_DIR = 1;  // port_direction_bit of inverted pin
  localparam int PC_CMPA_SYNC = 4;  // sync comparator a to timer tick
  localparam int PC_CMPB_SYNC = 5;  // sync comparator b to timer tick

  // status fields
  localparam int ST_STATE = 0;  // latch state
  localparam int ST_SET_IN = 1;  // combined set input
  localparam int ST_RST_IN = 2;  // combined reset input

  // reset values
  localparam logic [7:0] RST_CTRL_FIRST = 8'h00;
  localparam logic [7:0] RST_SOURCE_EN = 8'h00;
  localparam logic [7:0] RST_PIN_CFG = 8'h03;  // both pins inputs

  // periodic divider: shortest period, and counter width for 512
  localparam int DIV_MIN_PERIOD = 4;
  localparam int DIV_CNT_W = 9;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : srl_pkg

// ### rtl/srl_pulse_div.sv
// periodic one-cycle pulse generator with selectable power-of-two period
`timescale 1ns/10ps
module srl_pulse_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [srl_pkg::CF_DIV_W-1:0] div_sel,
  output logic pulse_q
);

  // free-running count of oscillator cycles
  logic [srl_pkg::DIV_CNT_W-1:0] cnt_q;
  // terminal count: period minus one, period = 4 << div_sel
  logic [srl_pkg::DIV_CNT_W-1:0] last_d;

  // period selection, codes ascending from 4 to 512 cycles
  always_comb begin
    last_d = srl_pkg::DIV_CNT_W'(
      (srl_pkg::DIV_MIN_PERIOD << div_sel) - 1);
  end

  // counter wraps at terminal count; a code change keeps the count, which wraps at once if already past the new terminal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (cnt_q >= last_d) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // one cycle wide pulse once per period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= (cnt_q >= last_d);
    end
  end

endmodule : srl_pulse_div

// ### verification/srl_latch_unit_properties.sv
// port assertions for the set-reset latch unit
`timescale 1ns/10ps
module srl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic true_out_pin_o,
  input wire logic true_out_pin_oe,
  input wire logic inverted_out_pin_o,
  input wire logic inverted_out_pin_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // disabled pin drivers carry no data
  gate_true_a: assert property (
    !true_out_pin_oe |-> !true_out_pin_o) else $error("true pin data leak");
  gate_inv_a: assert property (
    !inverted_out_pin_oe |-> !inverted_out_pin_o)
    else $error("inverted pin data leak");
  // both outputs on show opposite levels
  out_compl_a: assert property (
    true_out_pin_oe && inverted_out_pin_oe
    |-> true_out_pin_o != inverted_out_pin_o) else $error("outputs not opposite");
  // the true driver only turns on after a register write
  oe_by_write_a: assert property (
    $rose(true_out_pin_oe) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("oe rose without write");
  // write answer one cycle after both halves
  wr_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("bvalid late");
  rd_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rvalid late");
  // no new transfer while an answer is pending
  wr_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
  rd_busy_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  // reset quiets the write answer and pin drivers
  reset_idle_a: assert property (disable iff (1'h0)
    !aresetn |=> !s_axi_bvalid && !true_out_pin_oe && !inverted_out_pin_oe)
    else $error("outputs active after reset");
endmodule : srl_chk

bind srl_latch_unit srl_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .true_out_pin_o,
  .true_out_pin_oe, .inverted_out_pin_o, .inverted_out_pin_oe);

// ### verification/srl_latch_unit_tb_top.sv
// self-checking bench for the set-reset latch unit
`timescale 1ns/10ps
module srl_latch_unit_tb_top;
  logic aclk = 1'h0;  // 250 mhz
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic cmp_a_out, cmp_b_out, timer_clk_tick, latch_ext_input_pin;
  logic c_a = 1'h0, c_b = 1'h0, c_t = 1'h0, c_p = 1'h0;  // partner commands
  logic true_out_pin_o, true_out_pin_oe;
  logic inverted_out_pin_o, inverted_out_pin_oe;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;  // clock count
  int t;

  // clock and cycle count
  always #2 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  srl_latch_unit u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready(1'h1), .cmp_a_out, .cmp_b_out,
    .timer_clk_tick, .latch_ext_input_pin, .true_out_pin_o,
    .true_out_pin_oe, .inverted_out_pin_o, .inverted_out_pin_oe);

  srl_src_model u_src (.aclk, .cmd_a(c_a), .cmd_b(c_b), .cmd_tick(c_t),
    .cmd_pin(c_p), .cmp_a_out, .cmp_b_out, .timer_clk_tick,
    .latch_ext_input_pin);

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // axi write, both halves offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      aw_ok |= s_axi_awready;
      w_ok |= s_axi_wready;
      if (aw_ok) s_axi_awvalid <= 1'h0;
      if (w_ok) s_axi_wvalid <= 1'h0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  // axi read with expected data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    check(s_axi_rdata, exp);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd

  // pins as {true oe, true o, inverted oe, inverted o}
  task automatic pins(input logic [3:0] exp);
    repeat (6) @(posedge aclk);
    check({28'h0, true_out_pin_oe, true_out_pin_o, inverted_out_pin_oe,
           inverted_out_pin_o}, {28'h0, exp});
  endtask : pins

  // wait for the true pin to drop
  task automatic fall();
    do @(posedge aclk); while (true_out_pin_o !== 1'h1);
    do @(posedge aclk); while (true_out_pin_o !== 1'h0);
  endtask : fall

  // counts and verdict
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rd(srl_pkg::OFS_LATCH_CTRL_FIRST, 32'h0, srl_pkg::RESP_OKAY);
    rd(srl_pkg::OFS_LATCH_SOURCE_EN, 32'h0, srl_pkg::RESP_OKAY);
    rd(srl_pkg::OFS_PIN_CFG, 32'h3, srl_pkg::RESP_OKAY);
    rd(12'h010, 32'h0, srl_pkg::RESP_SLVERR);
    wr(srl_pkg::OFS_STATUS, 32'h1, srl_pkg::RESP_SLVERR);
    wr(srl_pkg::OFS_LATCH_CTRL_FIRST, 32'h01, srl_pkg::RESP_OKAY);
    wr(srl_pkg::OFS_PIN_CFG, 32'h0, srl_pkg::RESP_OKAY);
    wr(srl_pkg::OFS_LATCH_CTRL_FIRST, 32'h8c, srl_pkg::RESP_OKAY);
    pins(4'hb);
    wr(srl_pkg::OFS_LATCH_CTRL_FIRST, 32'h8e, srl_pkg::RESP_OKAY);
    pins(4'he);
    rd(srl_pkg::OFS_LATCH_CTRL_FIRST, 32'h8c, srl_pkg::RESP_OKAY);
    rd(srl_pkg::OFS_STATUS, 32'h1, srl_pkg::RESP_OKAY);
    wr(srl_pkg::OFS_LATCH_CTRL_FIRST, 32'h8f, srl_pkg::RESP_OKAY);
    pins(4'hb);
    wr(srl_pkg::OFS_PIN_CFG, 32'h1, srl_pkg::RESP_OKAY);
    pins(4'h3);
    wr(srl_pkg::OFS_LATCH_CTRL_FIRST, 32'h0c, srl_pkg::RESP_OKAY);
    pins(4'h0);
    // comparator a sets, comparator b resets
    wr(srl_pkg::OFS_PIN_CFG, 32'h0, srl_pkg::RESP_OKAY);
    wr(srl_pkg::OFS_LATCH_CTRL_FIRST, 32'h88, srl_pkg::RESP_OKAY);
    wr(srl_pkg::OFS_LATCH_SOURCE_EN, 32'h12, srl_pkg::RESP_OKAY);
    c_a <= 1'h1;
    pins(4'hc);
    c_a <= 1'h0;
    c_b <= 1'h1;
    pins(4'h8);
    c_b <= 1'h0;
    wr(srl_pkg::OFS_PIN_CFG, 32'h10, srl_pkg::RESP_OKAY);
    c_a <= 1'h1;
    pins(4'h8);
    c_t <= 1'h1;
    @(posedge aclk);
    c_t <= 1'h0;
    pins(4'hc);
    c_a <= 1'h0;
    // external pin as set source
    // synced comparator a still holds one: unroute it before the reset
    wr(srl_pkg::OFS_LATCH_SOURCE_EN, 32'h80, srl_pkg::RESP_OKAY);
    wr(srl_pkg::OFS_LATCH_CTRL_FIRST, 32'h89, srl_pkg::RESP_OKAY);
    pins(4'h8);
    c_p <= 1'h1;
    pins(4'hc);
    // pin holds set, periodic pulse resets one cycle per period
    wr(srl_pkg::OFS_LATCH_SOURCE_EN, 32'h84, srl_pkg::RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      wr(srl_pkg::OFS_LATCH_CTRL_FIRST, 32'h88 | (k << 4), srl_pkg::RESP_OKAY);
      fall();
      fall();
      t = cyc;
      fall();
      check(cyc - t, 32'h4 << k);
    end
    c_p <= 1'h0;
    summarize();
  end

  // hang guard, far above the expected run
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule : srl_latch_unit_tb_top

// ### verification/srl_src_model.sv
// comparator, timer tick and external pin partner for the bench
`timescale 1ns/10ps
module srl_src_model (
  input wire logic aclk,
  input wire logic cmd_a,
  input wire logic cmd_b,
  input wire logic cmd_tick,
  input wire logic cmd_pin,
  output logic cmp_a_out,
  output logic cmp_b_out,
  output logic timer_clk_tick,
  output logic latch_ext_input_pin
);
  // levels follow the bench one clock later, like a registered source
  always_ff @(posedge aclk) begin
    cmp_a_out <= cmd_a;
    cmp_b_out <= cmd_b;
    timer_clk_tick <= cmd_tick;  // one-cycle tick
    latch_ext_input_pin <= cmd_pin;
  end
endmodule : srl_src_model
